// File: dv/dtc_chk.sv
// Port checker for the four-channel transfer controller.
`timescale 1ns/10ps
module dtc_chk
  import dtc_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        rd_req_out,
  input wire logic [15:0] rd_addr_out,
  input wire logic [1:0]  rd_set_out,
  input wire logic        rd_err_in,
  input wire logic        wr_req_out,
  input wire logic [15:0] wr_addr_out,
  input wire logic [1:0]  wr_set_out,
  input wire logic [7:0]  wr_data_out,
  input wire logic        crc_valid_out,
  input wire logic [7:0]  crc_data_out,
  input wire logic [3:0]  irq_err_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  function automatic logic [1:0] set_of(input logic [15:0] a);
    return (a < EE_BASE) ? 2'h0 : (a < SRAM_BASE) ? 2'h1 : {1'h1, a[12]};
  endfunction : set_of

  a_rd_spaced: assert property (rd_req_out |=> !rd_req_out)
    else $error("Reads back to back");
  a_io_lat: assert property (rd_req_out && rd_addr_out < EE_BASE && !rd_err_in
    |-> ##2 wr_req_out)
    else $error("I/O access not one cycle");
  a_ee_lat: assert property (rd_req_out && set_of(rd_addr_out) == 2'h1
    |=> !wr_req_out ##[2:3] wr_req_out)
    else $error("EEPROM read timing wrong");
  a_sram_lat: assert property (rd_req_out && rd_addr_out >= SRAM_BASE
    |-> ##[2:3] wr_req_out)
    else $error("SRAM read timing wrong");
  a_rd_set: assert property (rd_req_out |-> rd_set_out == set_of(rd_addr_out))
    else $error("Read set wrong");
  a_wr_set: assert property (wr_req_out |-> wr_set_out == set_of(wr_addr_out))
    else $error("Write set wrong");
  a_crc_tie: assert property (crc_valid_out |-> wr_req_out && crc_data_out == wr_data_out)
    else $error("Checksum byte differs");
  a_resp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("Write response dropped");

  cover property (rd_req_out && rd_set_out == 2'h1);
  cover property (crc_valid_out);
  cover property (|irq_err_out);
endmodule : dtc_chk

// File: dv/dtc_ctrl_test.sv
// Self-checking bench of the transfer controller.
`timescale 1ns/10ps
module dtc_ctrl_test
  import dtc_pkg::*;
;
  logic        clk = 1'h0, rst = 1'h1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  preq = 4'h0, evt = 4'h0;
  wire         awready, wready, bvalid, arready, rvalid, rd_req, wr_req, rd_err, crc_v;
  wire  [1:0]  bresp, rresp, rd_set, wr_set;
  wire  [31:0] rdata;
  wire  [15:0] rd_addr, wr_addr;
  wire  [7:0]  rd_data, wr_data, crc_d;
  wire  [3:0]  irq_d, irq_e;
  int          mismatches = 0, samples_checked = 0, cyc = 0, nwr = 0;
  logic [31:0] rng = 32'hD9FD5069;
  logic [15:0] es, ed;
  logic [1:0]  sm;

  always #20 clk = ~clk;

  dtc_ctrl dut (.sys_clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .periph_req_in(preq), .event_in(evt), .rd_req_out(rd_req),
    .rd_addr_out(rd_addr), .rd_set_out(rd_set), .rd_data_in(rd_data), .rd_err_in(rd_err),
    .wr_req_out(wr_req), .wr_addr_out(wr_addr), .wr_set_out(wr_set),
    .wr_data_out(wr_data), .crc_valid_out(crc_v), .crc_data_out(crc_d),
    .irq_done_out(irq_d), .irq_err_out(irq_e));

  dtc_mem mem (.sys_clk_in(clk), .rd_req_in(rd_req), .rd_addr_in(rd_addr),
    .rd_data_out(rd_data), .rd_err_out(rd_err));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic end_of_test;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask : axr

  task automatic wait_irq(input logic e, input int ch);
    int k;
    k = 0;
    while ((e ? irq_e[ch] : irq_d[ch]) !== 1'h1 && k < 400)
    begin
      @(posedge clk);
      k++;
    end
  endtask : wait_irq

  // Each byte written must be the model's byte at the expected source.
  always @(posedge clk)
    if (!rst && wr_req)
    begin
      chk("wr_addr", {16'h0, ed}, {16'h0, wr_addr});
      chk("wr_data", {24'h0, es[7:0] ^ es[15:8] ^ 8'h5A}, {24'h0, wr_data});
      ed = ed + 16'h1;
      es = (sm == AM_INC) ? es + 16'h1 : (sm == AM_DEC) ? es - 16'h1 : es;
      nwr++;
    end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  initial
  begin
    logic [31:0] d, c;
    logic [1:0]  r, bl;
    logic [7:0]  b;
    logic [15:0] base [4];
    base = '{16'h2000, 16'h1000, 16'h0100, 16'h3000};
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    axr(OFF_CTRL, d, r);
    chk("ctrl_reset", CTRL_RST, d);
    axr(8'h7C, d, r);
    chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
    for (int ch = 0; ch < NCH; ch++)
    begin
      b   = 8'(ch * 32);
      rng = lfsr(rng);
      bl  = rng[1:0];
      sm  = (ch == 1) ? AM_INC : (ch == 2) ? AM_DEC : AM_FIX;
      es  = base[ch] + 16'h10 + {8'h0, rng[9:2]};
      ed  = base[3 - ch] + 16'h400;
      nwr = 0;
      c   = 32'h14001 | {bl, 2'h0} | {ch == 2, ch == 1, 4'h0} | {sm, 6'h0} | {AM_INC, 8'h0};
      axw(b + OFF_SRC, {16'h0, es});
      axw(b + OFF_DST, {16'h0, ed});
      axw(b + OFF_BLK, 32'h1 << bl);
      axw(b + OFF_REP, 32'h0);
      axw(b + OFF_CTRL, c);
      if (ch == 1) preq[1] <= 1'h1;
      else if (ch == 2) evt[2] <= 1'h1;
      else axw(b + OFF_CTRL, c | 32'h2);
      @(posedge clk);
      preq <= 4'h0;
      evt  <= 4'h0;
      wait_irq(1'h0, ch);
      chk("irq_done", 32'h1, {31'h0, irq_d[ch]});
      chk("bytes", 32'h1 << bl, nwr);
      axr(b + OFF_STAT, d, r);
      chk("stat", 32'h2, d & 32'hF);
      axr(b + OFF_CTRL, d, r);
      chk("enable", 32'h0, {31'h0, d[B_EN]});
      axw(b + OFF_STAT, 32'h2);
      repeat (2) @(posedge clk);
      chk("irq_clear", 32'h0, {31'h0, irq_d[ch]});
    end
    es  = 16'h0040;
    ed  = 16'h0500;
    sm  = AM_FIX;
    nwr = 0;
    axw(8'h20 + OFF_SRC, {16'h0, es});
    axw(8'h20 + OFF_BLK, 32'h1);
    axw(8'h20 + OFF_CTRL, 32'h20001);
    axw(8'h20 + OFF_CTRL, 32'h20003);
    wait_irq(1'h1, 1);
    chk("irq_err", 32'h1, {31'h0, irq_e[1]});
    chk("err_bytes", 32'h0, nwr);
    axr(8'h20 + OFF_STAT, d, r);
    chk("err_stat", 32'h4, d & 32'hF);
    end_of_test();
  end
endmodule : dtc_ctrl_test

bind dtc_ctrl dtc_chk u_chk (.*);

// File: dv/dtc_mem.sv
// Model of the memories and registers answering the controller's reads.
`timescale 1ns/10ps
module dtc_mem
  import dtc_pkg::*;
#(
  parameter logic [15:0] ERR_ADDR = 16'h0040
)
(
  input wire logic        sys_clk_in,
  input wire logic        rd_req_in,
  input wire logic [15:0] rd_addr_in,
  output logic [7:0]      rd_data_out,
  output logic            rd_err_out
);
  logic [15:0] addr_r = 16'h0000;
  logic [1:0]  age_r  = 2'h3;
  logic [15:0] ad;
  logic        ok;

  always_ff @(posedge sys_clk_in)
  begin
    if (rd_req_in)
    begin
      addr_r <= rd_addr_in;
      age_r  <= 2'h0;
    end
    else if (age_r != 2'h3)
      age_r <= age_r + 2'h1;
  end

  // Data hold only for the slowest access; after that they turn to noise.
  assign ad          = rd_req_in ? rd_addr_in : addr_r;
  assign ok          = rd_req_in || !age_r[1];
  assign rd_data_out = ok ? (ad[7:0] ^ ad[15:8] ^ 8'h5A) : ~(ad[7:0] ^ ad[15:8]);
  assign rd_err_out  = ok && ad == ERR_ADDR;
endmodule : dtc_mem

// File: rtl/dtc_ctrl.sv
// Four-channel direct_transfer_controller with AXI4-Lite registers and split memory ports.
//
// Notes on behaviour
// - Four channels, each running its own transfer independently of the others.
// - Each channel keeps its own source, destination, trigger, size and interrupt settings.
// - Bursts are uninterrupted and 1, 2, 4 or 8 bytes long.
// - A block holds one byte up to 64KB; zero in the size field means 64KB.
// - A repeat count repeats the block, up to 16MB per transaction.
// - Source and destination each stay fixed, increment or decrement per byte.
// - Addresses optionally reload to start after each burst, block or transaction.
// - Transfers start on software request, peripheral request or routed event.
// - Per-channel completion and error interrupt requests, each separately enabled.
// - Linked channels hand over to each other when a transaction finishes.
// - Moved bytes are optionally presented to the checksum generator.
// - Moves memory to memory, memory to peripheral, and peripheral to either.
// - The controller reads memory-mapped EEPROM like any data address.
// - Memory-mapped EEPROM starts at address 0x1000.
// - Data memory forms four sets; read and write sides report their sets.
// - I/O register accesses complete in one cycle.
// - SRAM writes take one cycle, single SRAM reads two.
// - Burst SRAM reads deliver a byte every cycle after the first.
// - EEPROM writes take one cycle, reads three, burst reads one per two cycles.
`timescale 1ns/10ps
module dtc_ctrl
  import dtc_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic [3:0]  periph_req_in,
  input  wire logic [3:0]  event_in,
  output logic             rd_req_out,
  output logic [15:0]      rd_addr_out,
  output logic [1:0]       rd_set_out,
  input  wire logic [7:0]  rd_data_in,
  input  wire logic        rd_err_in,
  output logic             wr_req_out,
  output logic [15:0]      wr_addr_out,
  output logic [1:0]       wr_set_out,
  output logic [7:0]       wr_data_out,
  output logic             crc_valid_out,
  output logic [7:0]       crc_data_out,
  output logic [3:0]       irq_done_out,
  output logic [3:0]       irq_err_out
);

  logic [31:0] ctrl_r [NCH];
  logic [15:0] blk_r  [NCH];
  logic [7:0]  rep_r  [NCH];
  logic [15:0] src0_r [NCH];
  logic [15:0] dst0_r [NCH];
  logic [15:0] src_r  [NCH];
  logic [15:0] dst_r  [NCH];
  logic [16:0] bleft_r [NCH];
  logic [7:0]  rleft_r [NCH];
  logic [3:0]  busy_r;
  logic [3:0]  done_r;
  logic [3:0]  err_r;
  logic [3:0]  pend_r;
  logic        rr_r;
  logic [1:0]  last_r;
  logic [7:0]  awa_r;
  logic [7:0]  ara_r;
  logic [31:0] wdat_r;
  logic [3:0]  wstb_r;
  logic        awh_r;
  logic        wh_r;
  logic        rd_pend_r;
  dtc_st_t     st_r;
  logic [1:0]  g_r;
  logic [1:0]  cnt_r;
  logic [3:0]  bcnt_r;
  logic        first_r;
  logic [7:0]  data_r;
  logic        wr_fire;
  logic        rd_fire;
  logic [3:0]  wsel;
  logic [3:0]  hit;
  logic [3:0]  start;
  logic [3:0]  avail;
  logic        any_av;
  logic [1:0]  pick;
  logic        mv;
  logic        blast;
  logic        blk_end;
  logic        txn_end;
  logic        err_ev;
  logic        rl_src;
  logic        rl_dst;
  logic [31:0] rmux;
  logic        rbad;
  logic        wbad;
  logic [31:0] gc;

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (s[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    return r;
  endfunction : wmerge

  function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] m);
    case (m)
      AM_INC:  step = a + 16'h0001;
      AM_DEC:  step = a - 16'h0001;
      default: step = a;
    endcase
  endfunction : step

  // Access time by region; burst reads after the first byte are cheaper.
  function automatic logic [1:0] acc_lat(input logic [15:0] a, input logic f);
    if (a < EE_BASE)
      acc_lat = LAT_IO;
    else if (a < SRAM_BASE)
      acc_lat = f ? LAT_EE : LAT_EE_BST;
    else
      acc_lat = f ? LAT_SRAM : LAT_SRAM_BST;
  endfunction : acc_lat

  // I/O, EEPROM and two SRAM halves form the four independently usable sets.
  function automatic logic [1:0] set_of(input logic [15:0] a);
    if (a < EE_BASE)
      set_of = 2'h0;
    else if (a < SRAM_BASE)
      set_of = 2'h1;
    else
      set_of = {1'b1, a[12]};
  endfunction : set_of

  assign wr_fire = awh_r && wh_r && !s_axi_bvalid_out;
  assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;
  assign mv      = (st_r == ST_WR);
  assign blast   = (bcnt_r == 4'h1) || (bleft_r[g_r] == 17'h00001);
  assign blk_end = (bleft_r[g_r] == 17'h00001);
  assign txn_end = blk_end && (rleft_r[g_r] == 8'h00);
  assign err_ev  = (st_r == ST_WAIT) && (cnt_r == 2'h1) && rd_err_in;
  assign gc      = ctrl_r[g_r];
  assign rl_src  = (gc[B_SRL +: 2] == RL_BURST && blast) ||
                   (gc[B_SRL +: 2] == RL_BLOCK && blk_end) ||
                   (gc[B_SRL +: 2] == RL_TXN && txn_end);
  assign rl_dst  = (gc[B_DRL +: 2] == RL_BURST && blast) ||
                   (gc[B_DRL +: 2] == RL_BLOCK && blk_end) ||
                   (gc[B_DRL +: 2] == RL_TXN && txn_end);
  assign wbad    = awa_r[7] ? (awa_r != OFF_GCTRL) : (awa_r[4:0] > OFF_STAT[4:0]);

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      wsel[c] = wr_fire && !awa_r[7] && (awa_r[6:5] == 2'(c));
      case (ctrl_r[c][B_TRG +: 2])
        TG_SW:   hit[c] = wsel[c] && (awa_r[4:0] == OFF_CTRL[4:0]) && wstb_r[0] &&
                          wdat_r[B_SWT];
        TG_PER:  hit[c] = periph_req_in[c];
        TG_EVT:  hit[c] = event_in[c];
        default: hit[c] = 1'b0;
      endcase
      start[c] = (wsel[c] && (awa_r[4:0] == OFF_CTRL[4:0]) && !ctrl_r[c][B_EN] &&
                  wstb_r[0] && wdat_r[B_EN]) ||
                 (mv && txn_end && gc[B_LNK] && (g_r == 2'(c ^ 1)));
      avail[c] = pend_r[c] && ctrl_r[c][B_EN];
    end
  end

  // Round robin starts searching just after the last served channel.
  always_comb
  begin
    logic [1:0] idx;
    idx    = 2'h0;
    pick   = 2'h0;
    any_av = 1'b0;
    for (int i = 0; i < NCH; i++)
    begin
      idx = rr_r ? last_r + 2'h1 + 2'(i) : 2'(i);
      if (avail[idx] && !any_av)
      begin
        pick   = idx;
        any_av = 1'b1;
      end
    end
  end

  always_comb
  begin
    rmux = 32'h00000000;
    rbad = 1'b0;
    if (ara_r == OFF_GCTRL)
      rmux = {31'h00000000, rr_r};
    else if (ara_r == OFF_GSTAT)
      rmux = {24'h000000, pend_r, busy_r};
    else if (ara_r[7])
      rbad = 1'b1;
    else
      case (ara_r[4:0])
        OFF_CTRL[4:0]: rmux = ctrl_r[ara_r[6:5]];
        OFF_BLK[4:0]:  rmux = {16'h0000, blk_r[ara_r[6:5]]};
        OFF_REP[4:0]:  rmux = {24'h000000, rep_r[ara_r[6:5]]};
        OFF_SRC[4:0]:  rmux = {16'h0000, src_r[ara_r[6:5]]};
        OFF_DST[4:0]:  rmux = {16'h0000, dst_r[ara_r[6:5]]};
        OFF_STAT[4:0]: rmux = {28'h0000000, pend_r[ara_r[6:5]], err_r[ara_r[6:5]],
                               done_r[ara_r[6:5]], busy_r[ara_r[6:5]]};
        default:       rbad = 1'b1;
      endcase
  end

  // Bus slave: address and data are held independently, the answer follows both.
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      awh_r             <= 1'b0;
      wh_r              <= 1'b0;
      awa_r             <= 8'h00;
      wdat_r            <= 32'h00000000;
      wstb_r            <= 4'h0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= RESP_OKAY;
      s_axi_rvalid_out  <= 1'b0;
      ara_r             <= 8'h00;
      s_axi_arready_out <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        awh_r <= 1'b1;
        awa_r <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        wh_r   <= 1'b1;
        wdat_r <= s_axi_wdata_in;
        wstb_r <= s_axi_wstrb_in;
      end
      if (wr_fire)
      begin
        awh_r            <= 1'b0;
        wh_r             <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wbad ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
      // Ready flops carry the value the held flags will have after this edge.
      s_axi_awready_out <= !wr_fire && !(awh_r || (s_axi_awvalid_in && s_axi_awready_out)) &&
                           !(s_axi_bvalid_out && !s_axi_bready_in);
      s_axi_wready_out  <= !wr_fire && !(wh_r || (s_axi_wvalid_in && s_axi_wready_out)) &&
                           !(s_axi_bvalid_out && !s_axi_bready_in);
      s_axi_arready_out <= !s_axi_arready_out && !s_axi_rvalid_out && !rd_pend_r &&
                           s_axi_arvalid_in;
      if (rd_fire)
        ara_r <= s_axi_araddr_in;
      if (s_axi_arready_out && !s_axi_arvalid_in)
        s_axi_arready_out <= 1'b0;
      if (rd_pend_r)
        s_axi_rvalid_out <= 1'b1;
      else if (s_axi_rvalid_out && s_axi_rready_in)
        s_axi_rvalid_out <= 1'b0;
    end
  end

  // Read data is formed one cycle after the address is taken, from the held address.
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      rd_pend_r <= 1'b0;
    else if (rd_fire)
      rd_pend_r <= 1'b1;
    else if (rd_pend_r)
      rd_pend_r <= 1'b0;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= RESP_OKAY;
    end
    else if (rd_pend_r)
    begin
      s_axi_rdata_out <= rmux;
      s_axi_rresp_out <= rbad ? RESP_SLVERR : RESP_OKAY;
    end
  end

  // Channel configuration and run state; software writes follow engine updates so they win, except starts and done and error sets, which come after them.
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        ctrl_r[c]  <= CTRL_RST;
        blk_r[c]   <= 16'h0000;
        rep_r[c]   <= 8'h00;
        src0_r[c]  <= 16'h0000;
        dst0_r[c]  <= 16'h0000;
        src_r[c]   <= 16'h0000;
        dst_r[c]   <= 16'h0000;
        bleft_r[c] <= 17'h00000;
        rleft_r[c] <= 8'h00;
      end
      busy_r <= 4'h0;
      done_r <= 4'h0;
      err_r  <= 4'h0;
      pend_r <= 4'h0;
      rr_r   <= 1'b0;
    end
    else
    begin
      if (st_r == ST_IDLE && any_av)
        busy_r[pick] <= 1'b1;
      if (mv)
      begin
        src_r[g_r]   <= rl_src ? src0_r[g_r] : step(src_r[g_r], gc[B_SAM +: 2]);
        dst_r[g_r]   <= rl_dst ? dst0_r[g_r] : step(dst_r[g_r], gc[B_DAM +: 2]);
        bleft_r[g_r] <= bleft_r[g_r] - 17'h00001;
        if (blast)
          pend_r[g_r] <= 1'b0;
        if (blk_end)
        begin
          bleft_r[g_r] <= {blk_r[g_r] == 16'h0000, blk_r[g_r]};
          rleft_r[g_r] <= rleft_r[g_r] - 8'h01;
        end
        if (txn_end)
        begin
          rleft_r[g_r] <= rep_r[g_r];
          if (!gc[B_CONT])
          begin
            busy_r[g_r]       <= 1'b0;
            ctrl_r[g_r][B_EN] <= 1'b0;
          end
        end
      end
      if (err_ev)
      begin
        busy_r[g_r]       <= 1'b0;
        pend_r[g_r]       <= 1'b0;
        ctrl_r[g_r][B_EN] <= 1'b0;
      end
      if (wr_fire && awa_r == OFF_GCTRL && wstb_r[0])
        rr_r <= wdat_r[0];
      for (int c = 0; c < NCH; c++)
      begin
        if (wsel[c])
          case (awa_r[4:0])
            OFF_CTRL[4:0]: ctrl_r[c] <= wmerge(ctrl_r[c], wdat_r, wstb_r) & CTRL_MASK;
            OFF_BLK[4:0]:  blk_r[c] <= 16'(wmerge({16'h0000, blk_r[c]}, wdat_r, wstb_r));
            OFF_REP[4:0]:  rep_r[c] <= 8'(wmerge({24'h000000, rep_r[c]}, wdat_r, wstb_r));
            OFF_SRC[4:0]:
            begin
              src0_r[c] <= 16'(wmerge({16'h0000, src0_r[c]}, wdat_r, wstb_r));
              src_r[c]  <= 16'(wmerge({16'h0000, src0_r[c]}, wdat_r, wstb_r));
            end
            OFF_DST[4:0]:
            begin
              dst0_r[c] <= 16'(wmerge({16'h0000, dst0_r[c]}, wdat_r, wstb_r));
              dst_r[c]  <= 16'(wmerge({16'h0000, dst0_r[c]}, wdat_r, wstb_r));
            end
            OFF_STAT[4:0]:
            begin
              if (wstb_r[0] && wdat_r[S_DONE])
                done_r[c] <= 1'b0;
              if (wstb_r[0] && wdat_r[S_ERR])
                err_r[c] <= 1'b0;
            end
            default: ;
          endcase
        if (start[c])
        begin
          ctrl_r[c][B_EN] <= 1'b1;
          bleft_r[c]      <= {blk_r[c] == 16'h0000, blk_r[c]};
          rleft_r[c]      <= rep_r[c];
          src_r[c]        <= src0_r[c];
          dst_r[c]        <= dst0_r[c];
        end
        if (hit[c] && (ctrl_r[c][B_EN] || start[c]))
          pend_r[c] <= 1'b1;
        if (mv && txn_end && g_r == 2'(c))
          done_r[c] <= 1'b1;
        if (err_ev && g_r == 2'(c))
          err_r[c] <= 1'b1;
      end
    end
  end

  // One engine serves a granted channel for a whole burst before arbitrating again.
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      st_r          <= ST_IDLE;
      g_r           <= 2'h0;
      last_r        <= 2'h3;
      cnt_r         <= 2'h0;
      bcnt_r        <= 4'h0;
      first_r       <= 1'b0;
      data_r        <= 8'h00;
      rd_req_out    <= 1'b0;
      rd_addr_out   <= 16'h0000;
      rd_set_out    <= 2'h0;
      wr_req_out    <= 1'b0;
      wr_addr_out   <= 16'h0000;
      wr_set_out    <= 2'h0;
      wr_data_out   <= 8'h00;
      crc_valid_out <= 1'b0;
      crc_data_out  <= 8'h00;
    end
    else
    begin
      rd_req_out    <= 1'b0;
      wr_req_out    <= 1'b0;
      crc_valid_out <= 1'b0;
      case (st_r)
        ST_IDLE:
          if (any_av)
          begin
            g_r     <= pick;
            last_r  <= pick;
            bcnt_r  <= 4'h1 << ctrl_r[pick][B_BL +: 2];
            first_r <= 1'b1;
            st_r    <= ST_RD;
          end
        ST_RD:
        begin
          rd_req_out  <= 1'b1;
          rd_addr_out <= src_r[g_r];
          rd_set_out  <= set_of(src_r[g_r]);
          cnt_r       <= acc_lat(src_r[g_r], first_r);
          first_r     <= 1'b0;
          st_r        <= ST_WAIT;
        end
        ST_WAIT:
          if (cnt_r == 2'h1)
          begin
            data_r <= rd_data_in;
            st_r   <= rd_err_in ? ST_IDLE : ST_WR;
          end
          else
            cnt_r <= cnt_r - 2'h1;
        ST_WR:
        begin
          wr_req_out    <= 1'b1;
          wr_addr_out   <= dst_r[g_r];
          wr_set_out    <= set_of(dst_r[g_r]);
          wr_data_out   <= data_r;
          crc_valid_out <= gc[B_CRC];
          crc_data_out  <= data_r;
          bcnt_r        <= bcnt_r - 4'h1;
          st_r          <= blast ? ST_IDLE : ST_RD;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_irq
      always_ff @(posedge sys_clk_in)
      begin
        if (rst_in)
        begin
          irq_done_out[gi] <= 1'b0;
          irq_err_out[gi]  <= 1'b0;
        end
        else
        begin
          irq_done_out[gi] <= done_r[gi] && ctrl_r[gi][B_DIE];
          irq_err_out[gi]  <= err_r[gi] && ctrl_r[gi][B_EIE];
        end
      end
    end
  endgenerate

endmodule : dtc_ctrl

// File: rtl/dtc_pkg.sv
// Constants, register map and types of the four-channel transfer controller.
package dtc_pkg;
  localparam int          NCH          = 4;
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_BLK      = 8'h04;
  localparam logic [7:0]  OFF_REP      = 8'h08;
  localparam logic [7:0]  OFF_SRC      = 8'h0C;
  localparam logic [7:0]  OFF_DST      = 8'h10;
  localparam logic [7:0]  OFF_STAT     = 8'h14;
  localparam logic [7:0]  OFF_GCTRL    = 8'h80;
  localparam logic [7:0]  OFF_GSTAT    = 8'h84;
  localparam int          B_EN         = 0;
  localparam int          B_SWT        = 1;
  localparam int          B_BL         = 2;
  localparam int          B_TRG        = 4;
  localparam int          B_SAM        = 6;
  localparam int          B_DAM        = 8;
  localparam int          B_SRL        = 10;
  localparam int          B_DRL        = 12;
  localparam int          B_CRC        = 14;
  localparam int          B_LNK        = 15;
  localparam int          B_DIE        = 16;
  localparam int          B_EIE        = 17;
  localparam int          B_CONT       = 18;
  localparam logic [31:0] CTRL_MASK    = 32'h0007FFFD;
  localparam logic [31:0] CTRL_RST     = 32'h00000000;
  localparam int          S_BUSY       = 0;
  localparam int          S_DONE       = 1;
  localparam int          S_ERR        = 2;
  localparam int          S_PEND       = 3;
  localparam logic [15:0] EE_BASE      = 16'h1000;
  localparam logic [15:0] SRAM_BASE    = 16'h2000;
  localparam logic [1:0]  LAT_IO       = 2'h1;
  localparam logic [1:0]  LAT_SRAM     = 2'h2;
  localparam logic [1:0]  LAT_SRAM_BST = 2'h1;
  localparam logic [1:0]  LAT_EE       = 2'h3;
  localparam logic [1:0]  LAT_EE_BST   = 2'h2;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  typedef enum logic [1:0] {AM_FIX = 2'b00, AM_INC = 2'b01, AM_DEC = 2'b10} dtc_am_t;
  typedef enum logic [1:0] {RL_NONE = 2'b00, RL_BURST = 2'b01, RL_BLOCK = 2'b10,
                            RL_TXN = 2'b11} dtc_rl_t;
  typedef enum logic [1:0] {TG_SW = 2'b00, TG_PER = 2'b01, TG_EVT = 2'b10} dtc_tg_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RD = 2'b01, ST_WAIT = 2'b10,
                            ST_WR = 2'b11} dtc_st_t;
endpackage : dtc_pkg
